//--- pdsc_checker.sv
// Lockstep comparator of the power-state controller and its diagnostic copy.
// Assumes both copies are fed from the same clock and reset.
`timescale 1ns/1ps
module pdsc_checker #(
    parameter int unsigned N = 4
) (
    input  wire logic     clk_i,
    input  wire logic     rst_i,
    pdsc_lock_if.mon      lk,
    output logic [N-1:0]  mism_pwr_o,
    output logic [N-1:0]  mism_st_o
);
    logic [N-1:0] pwr_d;
    logic [N-1:0] st_d;

    always_comb
    begin
        pwr_d = '0;
        st_d  = '0;
        for (int i = 0; i < int'(N); i++)
        begin
            pwr_d[i] = lk.active && (lk.p_pwr[i] != lk.d_pwr[i]);
            st_d[i]  = lk.active && (lk.p_state[2*i +: 2] != lk.d_state[2*i +: 2]);
        end
    end

    // One register stage keeps the compare off the bus timing path.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mism_pwr_o <= '0;
            mism_st_o  <= '0;
        end
        else
        begin
            mism_pwr_o <= pwr_d;
            mism_st_o  <= st_d;
        end
    end

    property p_lock_mismatch;
        @(posedge clk_i) disable iff (rst_i)
        (lk.active && (lk.p_pwr != lk.d_pwr)) |=> (mism_pwr_o != '0);
    endproperty
    a_lock_mismatch: assert property (p_lock_mismatch)
        else $error("power-enable difference not flagged");

    property p_no_false;
        @(posedge clk_i) disable iff (rst_i)
        !lk.inject [*2] |=> (mism_pwr_o == '0) && (mism_st_o == '0);
    endproperty
    a_no_false: assert property (p_no_false)
        else $error("compare error without any injected difference");

endmodule : pdsc_checker

//--- pdsc_domain.sv
// Power sequencer of one switchable logic domain.
// Assumes synchronised power-good and strap inputs on the common clock.
`timescale 1ns/1ps
module pdsc_domain #(
    parameter int unsigned SETTLE_CYC = pdsc_pkg::PG_SETTLE_CYC,
    parameter int unsigned BOOT_LEN   = pdsc_pkg::BOOT_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       otp_off_i,
    input  wire logic       start_i,
    input  wire logic       pg_i,
    output logic [1:0]      state_o,
    output logic            pwr_en_o
);
    localparam int unsigned CW = $clog2(SETTLE_CYC + BOOT_LEN + 1);

    pdsc_pkg::pdsc_dom_t st_q;
    pdsc_pkg::pdsc_dom_t st_d;
    logic [CW-1:0]       cnt_q;
    logic [CW-1:0]       cnt_d;

    // Next state; only a system reset leaves the off state.
    always_comb
    begin
        st_d  = st_q;
        cnt_d = cnt_q;
        case (st_q)
            pdsc_pkg::DOM_BOOT:
            begin
                if (cnt_q == CW'(BOOT_LEN - 1))
                begin
                    cnt_d = '0;
                    st_d  = otp_off_i ? pdsc_pkg::DOM_DRAIN : pdsc_pkg::DOM_ON;
                end
                else
                begin
                    cnt_d = cnt_q + CW'(1);
                end
            end
            pdsc_pkg::DOM_ON:
            begin
                if (start_i)
                begin
                    st_d = pdsc_pkg::DOM_DRAIN;
                end
            end
            pdsc_pkg::DOM_DRAIN:
            begin
                if (!pg_i)
                begin
                    st_d  = pdsc_pkg::DOM_SETTLE;
                    cnt_d = '0;
                end
            end
            pdsc_pkg::DOM_SETTLE:
            begin
                if (cnt_q == CW'(SETTLE_CYC - 1))
                begin
                    st_d = pdsc_pkg::DOM_OFF;
                end
                else
                begin
                    cnt_d = cnt_q + CW'(1);
                end
            end
            default:
            begin
                st_d = pdsc_pkg::DOM_OFF;
            end
        endcase
    end

    // State registers.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q  <= pdsc_pkg::DOM_BOOT;
            cnt_q <= '0;
        end
        else
        begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
        end
    end

    assign state_o  = (st_q == pdsc_pkg::DOM_OFF) ? pdsc_pkg::ST_OFF :
                      (st_q == pdsc_pkg::DOM_ON)  ? pdsc_pkg::ST_ON  : pdsc_pkg::ST_BUSY;
    assign pwr_en_o = (st_q == pdsc_pkg::DOM_ON);

endmodule : pdsc_domain

//--- pdsc_lock_if.sv
// Lockstep bundle between the power-state controller pair and the checker.
// Assumes both controller copies run on the same clock as the checker.
`timescale 1ns/1ps
interface pdsc_lock_if #(parameter int unsigned N = 4);
    logic [2*N-1:0] p_state;
    logic [2*N-1:0] d_state;
    logic [N-1:0]   p_pwr;
    logic [N-1:0]   d_pwr;
    logic           active;
    logic           inject;

    modport ctrl (output p_state, output d_state, output p_pwr, output d_pwr,
                  output active, output inject);
    modport mon  (input p_state, input d_state, input p_pwr, input d_pwr,
                  input active, input inject);
endinterface : pdsc_lock_if

//--- pdsc_pkg.sv
// Shared constants and types of the power-domain shutdown block with its
// lockstep power-state checker and error flag group.
// Assumes a 32-bit classic Wishbone register bus and a single 25 MHz clock.
package pdsc_pkg;

    // Number of switchable logic domains.
    localparam int unsigned NUM_DOM = 4;

    // Register byte addresses.
    localparam logic [31:0] ADR_CLKDIS_SET   = 32'hFFFF0080;
    localparam logic [31:0] ADR_PWR_CTRL     = 32'hFFFF0090;
    localparam logic [31:0] ADR_PWR_STATE0   = 32'hFFFF00A0;
    localparam logic [31:0] ADR_CMP_STAT     = 32'hFFFF00B0;
    localparam logic [31:0] ADR_CHK_CTRL     = 32'hFFFF00B4;
    localparam logic [31:0] ADR_ERR_FLAGS    = 32'hFFFFF558;
    localparam logic [31:0] ADR_IRQ_EN_SET   = 32'hFFFFF560;
    localparam logic [31:0] ADR_PIN_EN_SET   = 32'hFFFFF564;
    localparam logic [31:0] ADR_IRQ_EN_CLR   = 32'hFFFFF568;
    localparam logic [31:0] ADR_PIN_EN_CLR   = 32'hFFFFF56C;

    // Field layout.
    localparam logic [3:0]  PD_CODE          = 4'hA;
    localparam int unsigned PD_FIELD_W       = 4;
    localparam int unsigned CMP_FLAG_LSB     = 16;
    localparam int unsigned ERR_CH_PWR       = 6;   // Channel 38 of group 1.
    localparam int unsigned ERR_CH_ST        = 7;   // Channel 39 of group 1.

    // Power-state field encodings.
    localparam logic [1:0]  ST_OFF           = 2'h0;
    localparam logic [1:0]  ST_ON            = 2'h1;
    localparam logic [1:0]  ST_BUSY          = 2'h2;

    // Reset values.
    localparam logic [31:0] RESET_VECTOR     = 32'h00000000;
    localparam logic [31:0] DATA_RST         = 32'h00000000;

    // Timing.
    localparam int unsigned CLK_PERIOD_NS    = 40;
    localparam int unsigned PG_SETTLE_NS     = 1000;
    localparam int unsigned PG_SETTLE_CYC    =
        (PG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BOOT_CYC         = 3;

    // Per-domain sequencer states.
    typedef enum logic [2:0] {
        DOM_BOOT,
        DOM_ON,
        DOM_DRAIN,
        DOM_SETTLE,
        DOM_OFF
    } pdsc_dom_t;

endpackage : pdsc_pkg

//--- pdsc_top.sv
// Power-domain shutdown block: per-domain sequencers in duplicate, lockstep
// checker, compare flags, group 1 error flags and warm-reset vector output.
// Assumes a classic Wishbone master on clk_i; power-good, strap and warm-reset
// pins arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
// Notes on behaviour
// - Power-down alone never yields a compare error.
// - Strap keeps a domain off from reset.
// - Code 0xA in a field starts power-down once that domain's clock is disabled.
// - State field reads 00 once fully off.
// - Writing 0x000F0000 clears all compare flags.
// - Persisting mismatch sets its flag again immediately.
// - Compare errors report on channels 38, 39.
// - Writing 0xC0 clears channel 38, 39 flags.
// - Off domain returns only by system reset.
// - Warm reset restarts CPU at address zero.
// - Controller and copy compared after initialization.
module pdsc_top #(
    parameter int unsigned N = pdsc_pkg::NUM_DOM
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         cyc_i,
    input  wire logic         stb_i,
    input  wire logic         we_i,
    input  wire logic [3:0]   sel_i,
    input  wire logic [31:0]  adr_i,
    input  wire logic [31:0]  dat_i,
    output logic [31:0]       dat_o,
    output logic              ack_o,
    input  wire logic [N-1:0] otp_dom_off_i,
    input  wire logic [N-1:0] dom_pg_i,
    input  wire logic         warm_rst_i,
    output logic [N-1:0]      dom_pwr_en_o,
    output logic [N-1:0]      dom_clk_en_o,
    output logic              irq_o,
    output logic              error_pin_n_o,
    output logic              cpu_rst_o,
    output logic [31:0]       cpu_reset_vector_o
);
    // Pin synchronisers; only the second stages are read by logic.
    logic [N-1:0] otp_m_q;
    logic [N-1:0] otp_s_q;
    logic [N-1:0] pg_m_q;
    logic [N-1:0] pg_s_q;
    logic         warm_m_q;
    logic         warm_s_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            otp_m_q  <= '0;
            otp_s_q  <= '0;
            pg_m_q   <= '0;
            pg_s_q   <= '0;
            warm_m_q <= 1'b0;
            warm_s_q <= 1'b0;
        end
        else
        begin
            otp_m_q  <= otp_dom_off_i;
            otp_s_q  <= otp_m_q;
            pg_m_q   <= dom_pg_i;
            pg_s_q   <= pg_m_q;
            warm_m_q <= warm_rst_i;
            warm_s_q <= warm_m_q;
        end
    end

    // Register state.
    logic [N-1:0]   clkdis_q, clkdis_d;
    logic [4*N-1:0] pwrctl_q, pwrctl_d;
    logic           inject_q, inject_d;
    logic [N-1:0]   cmp_q, cmp_d;
    logic [1:0]     err_q, err_d;
    logic [1:0]     irq_en_q, irq_en_d;
    logic [1:0]     pin_en_q, pin_en_d;
    logic           active_q, active_d;
    logic           ack_q;
    logic [31:0]    dat_q, dat_d;

    logic           wr;
    logic           rd;
    logic [31:0]    wmask;
    logic [N-1:0]   start;
    logic [N-1:0]   mism_pwr;
    logic [N-1:0]   mism_st;
    logic [N-1:0]   mism;

    pdsc_lock_if #(.N(N)) lk ();

    assign wr    = cyc_i && stb_i && we_i && !ack_q;
    assign rd    = cyc_i && stb_i && !we_i && !ack_q;
    assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    assign mism  = mism_pwr | mism_st;

    // Primary controller and its diagnostic copy share every input but power-good
    // injection, so a shutdown never makes them disagree on its own.
    // identical copy inputs
    genvar g;
    generate
        for (g = 0; g < int'(N); g++)
        begin : g_dom
            assign start[g] = wr && (adr_i == pdsc_pkg::ADR_PWR_CTRL) && sel_i[g/2]
                              && (dat_i[4*g +: 4] == pdsc_pkg::PD_CODE) && clkdis_q[g];
            pdsc_domain u_pri (
                .clk_i     (clk_i),
                .rst_i     (rst_i),
                .otp_off_i (otp_s_q[g]),
                .start_i   (start[g]),
                .pg_i      (pg_s_q[g]),
                .state_o   (lk.p_state[2*g +: 2]),
                .pwr_en_o  (lk.p_pwr[g])
            );
            pdsc_domain u_diag (
                .clk_i     (clk_i),
                .rst_i     (rst_i),
                .otp_off_i (otp_s_q[g]),
                .start_i   (start[g]),
                .pg_i      (pg_s_q[g] ^ inject_q),
                .state_o   (lk.d_state[2*g +: 2]),
                .pwr_en_o  (lk.d_pwr[g])
            );
        end
    endgenerate

    assign lk.active = active_q;
    assign lk.inject = inject_q;

    pdsc_checker #(.N(N)) u_chk (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .lk         (lk),
        .mism_pwr_o (mism_pwr),
        .mism_st_o  (mism_st)
    );

    // Register writes, flag updates and read mux. Hardware sets win over clears.
    always_comb
    begin
        clkdis_d = clkdis_q;
        pwrctl_d = pwrctl_q;
        inject_d = inject_q;
        irq_en_d = irq_en_q;
        pin_en_d = pin_en_q;
        cmp_d    = cmp_q;
        err_d    = err_q;
        dat_d    = pdsc_pkg::DATA_RST;
        // Comparison starts once every primary sequencer has left boot.
        active_d = active_q;
        if (!active_q)
        begin
            active_d = 1'b1;
            for (int i = 0; i < int'(N); i++)
            begin
                if (lk.p_state[2*i +: 2] == pdsc_pkg::ST_BUSY && !lk.p_pwr[i]
                    && otp_s_q[i] == 1'b0 && lk.p_state[2*i +: 2] != pdsc_pkg::ST_OFF)
                begin
                    active_d = 1'b0;
                end
            end
        end
        if (wr)
        begin
            if (adr_i == pdsc_pkg::ADR_CLKDIS_SET)
            begin
                clkdis_d = clkdis_q | (dat_i[N-1:0] & wmask[N-1:0]);
            end
            else if (adr_i == pdsc_pkg::ADR_PWR_CTRL)
            begin
                pwrctl_d = (pwrctl_q & ~wmask[4*N-1:0]) | (dat_i[4*N-1:0] & wmask[4*N-1:0]);
            end
            else if (adr_i == pdsc_pkg::ADR_CMP_STAT)
            begin
                cmp_d = cmp_q & ~(dat_i[pdsc_pkg::CMP_FLAG_LSB +: N]
                                  & wmask[pdsc_pkg::CMP_FLAG_LSB +: N]);
            end
            else if (adr_i == pdsc_pkg::ADR_CHK_CTRL)
            begin
                inject_d = sel_i[0] ? dat_i[0] : inject_q;
            end
            else if (adr_i == pdsc_pkg::ADR_ERR_FLAGS)
            begin
                err_d = err_q & ~(dat_i[pdsc_pkg::ERR_CH_PWR +: 2] & {2{sel_i[0]}});
            end
            else if (adr_i == pdsc_pkg::ADR_IRQ_EN_SET)
            begin
                irq_en_d = irq_en_q | (dat_i[pdsc_pkg::ERR_CH_PWR +: 2] & {2{sel_i[0]}});
            end
            else if (adr_i == pdsc_pkg::ADR_PIN_EN_SET)
            begin
                pin_en_d = pin_en_q | (dat_i[pdsc_pkg::ERR_CH_PWR +: 2] & {2{sel_i[0]}});
            end
            else if (adr_i == pdsc_pkg::ADR_IRQ_EN_CLR)
            begin
                irq_en_d = irq_en_q & ~(dat_i[pdsc_pkg::ERR_CH_PWR +: 2] & {2{sel_i[0]}});
            end
            else if (adr_i == pdsc_pkg::ADR_PIN_EN_CLR)
            begin
                pin_en_d = pin_en_q & ~(dat_i[pdsc_pkg::ERR_CH_PWR +: 2] & {2{sel_i[0]}});
            end
        end
        cmp_d = cmp_d | mism;
        err_d = err_d | {(|mism_st), (|mism_pwr)};
        if (rd)
        begin
            if (adr_i == pdsc_pkg::ADR_CLKDIS_SET)
            begin
                dat_d[N-1:0] = clkdis_q;
            end
            else if (adr_i == pdsc_pkg::ADR_PWR_CTRL)
            begin
                dat_d[4*N-1:0] = pwrctl_q;
            end
            else if (adr_i[31:4] == pdsc_pkg::ADR_PWR_STATE0[31:4])
            begin
                dat_d[1:0] = lk.p_state[2*adr_i[3:2] +: 2];
            end
            else if (adr_i == pdsc_pkg::ADR_CMP_STAT)
            begin
                dat_d[pdsc_pkg::CMP_FLAG_LSB +: N] = cmp_q;
            end
            else if (adr_i == pdsc_pkg::ADR_CHK_CTRL)
            begin
                dat_d[0] = inject_q;
            end
            else if (adr_i == pdsc_pkg::ADR_ERR_FLAGS)
            begin
                dat_d[pdsc_pkg::ERR_CH_PWR +: 2] = err_q;
            end
            else if (adr_i == pdsc_pkg::ADR_IRQ_EN_SET)
            begin
                dat_d[pdsc_pkg::ERR_CH_PWR +: 2] = irq_en_q;
            end
            else if (adr_i == pdsc_pkg::ADR_PIN_EN_SET)
            begin
                dat_d[pdsc_pkg::ERR_CH_PWR +: 2] = pin_en_q;
            end
        end
    end

    // Registers and registered outputs. A warm reset touches only the CPU reset.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            clkdis_q           <= '0;
            pwrctl_q           <= '0;
            inject_q           <= 1'b0;
            cmp_q              <= '0;
            err_q              <= '0;
            irq_en_q           <= '0;
            pin_en_q           <= '0;
            active_q           <= 1'b0;
            ack_q              <= 1'b0;
            dat_q              <= pdsc_pkg::DATA_RST;
            dom_pwr_en_o       <= '0;
            dom_clk_en_o       <= '0;
            irq_o              <= 1'b0;
            error_pin_n_o      <= 1'b1;
            cpu_rst_o          <= 1'b1;
            cpu_reset_vector_o <= pdsc_pkg::RESET_VECTOR;
        end
        else
        begin
            clkdis_q           <= clkdis_d;
            pwrctl_q           <= pwrctl_d;
            inject_q           <= inject_d;
            cmp_q              <= cmp_d;
            err_q              <= err_d;
            irq_en_q           <= irq_en_d;
            pin_en_q           <= pin_en_d;
            active_q           <= active_d;
            ack_q              <= cyc_i && stb_i && !ack_q;
            dat_q              <= dat_d;
            dom_pwr_en_o       <= lk.p_pwr;
            dom_clk_en_o       <= lk.p_pwr & ~clkdis_q;
            irq_o              <= |(err_q & irq_en_q);
            error_pin_n_o      <= ~|(err_q & pin_en_q);
            cpu_rst_o          <= warm_s_q;
            cpu_reset_vector_o <= pdsc_pkg::RESET_VECTOR;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;

    property p_start;
        @(posedge clk_i) disable iff (rst_i)
        start[0] && (lk.p_state[1:0] == pdsc_pkg::ST_ON) |=> lk.p_state[1:0] == pdsc_pkg::ST_BUSY;
    endproperty
    a_start: assert property (p_start)
        else $error("power-down code did not start shutdown");

    property p_busy;
        @(posedge clk_i) disable iff (rst_i)
        $past(lk.p_state[1:0]) == pdsc_pkg::ST_ON && lk.p_state[1:0] != pdsc_pkg::ST_ON
        |-> lk.p_state[1:0] == pdsc_pkg::ST_BUSY [*2];
    endproperty
    a_busy: assert property (p_busy)
        else $error("state field left on without showing busy");

    property p_stay_off;
        @(posedge clk_i) disable iff (rst_i)
        lk.p_state[1:0] == pdsc_pkg::ST_OFF |=> lk.p_state[1:0] == pdsc_pkg::ST_OFF && !lk.p_pwr[0];
    endproperty
    a_stay_off: assert property (p_stay_off)
        else $error("off domain came back without system reset");

    property p_strap;
        @(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) ##2 otp_s_q[N-1] |-> !lk.p_pwr[N-1] [*6];
    endproperty
    a_strap: assert property (p_strap)
        else $error("strapped-off domain was powered");

    property p_cmp_clr;
        @(posedge clk_i) disable iff (rst_i)
        wr && adr_i == pdsc_pkg::ADR_CMP_STAT && dat_i == 32'h000F0000 && sel_i == 4'hF
        && mism == '0 |=> cmp_q == '0;
    endproperty
    a_cmp_clr: assert property (p_cmp_clr)
        else $error("compare flags not cleared");

    property p_reset_flag;
        @(posedge clk_i) disable iff (rst_i)
        (mism != '0) |=> ((cmp_q & $past(mism)) == $past(mism)) && err_q != 2'h0;
    endproperty
    a_reset_flag: assert property (p_reset_flag)
        else $error("persisting mismatch did not set its flags");

    property p_err_clr;
        @(posedge clk_i) disable iff (rst_i)
        wr && adr_i == pdsc_pkg::ADR_ERR_FLAGS && dat_i == 32'h000000C0 && sel_i[0]
        && mism == '0 |=> err_q == 2'h0 ##2 irq_o == 1'b0;
    endproperty
    a_err_clr: assert property (p_err_clr)
        else $error("channel 38 and 39 flags not cleared");

    property p_warm;
        @(posedge clk_i) disable iff (rst_i)
        $rose(warm_s_q) |=> cpu_rst_o && cpu_reset_vector_o == 32'h00000000;
    endproperty
    a_warm: assert property (p_warm)
        else $error("warm reset did not restart the CPU at zero");

endmodule : pdsc_top

//--- power_domain_shutdown_check_tb.sv
// Self-checking bench of the power-domain shutdown block with its checker.
// Assumes a one-cycle Wishbone ack and supplies that follow their enables.
`timescale 1ns/1ps
module power_domain_shutdown_check_tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic [31:0] adr   = 32'h0;
    logic [31:0] dat   = 32'h0;
    logic [3:0]  otp   = 4'h8;  // Domain 3 is strapped off.
    logic [3:0]  pg    = 4'h0;
    logic [3:0]  pg_hold = 4'h0;  // Keeps a supply up to stall a shutdown.
    logic        warm  = 1'b0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [3:0]  pwr_en;
    logic [3:0]  clk_en;
    logic        irq;
    logic        pin_n;
    logic        cpu_rst;
    logic [31:0] vec;
    logic [31:0] rd;
    int          errors = 0;
    int          checks_done = 0;

    pdsc_top i_pdsc_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .sel_i(4'hF), .adr_i(adr), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
        .otp_dom_off_i(otp), .dom_pg_i(pg), .warm_rst_i(warm), .dom_pwr_en_o(pwr_en),
        .dom_clk_en_o(clk_en), .irq_o(irq), .error_pin_n_o(pin_n), .cpu_rst_o(cpu_rst),
        .cpu_reset_vector_o(vec));

    // The clock toggles every half period of 40 ns.
    always #20 clk_i = ~clk_i;

    // Power-good trails the enable by a cycle, as a slow supply would.
    always @(posedge clk_i)
        pg <= pwr_en | pg_hold;

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    // Compares a seen value with the expected one.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // One classic cycle; the request is held until ack is sampled high.
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        for (n = 0; n < 20 && ack_o !== 1'b1; n++)
            @(posedge clk_i);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        if (ack_o !== 1'b1)
        begin
            chk(32'h0, 32'h1, "bus ack timeout");
            report_and_stop();
        end
    endtask : wb

    // Reads a register and compares it.
    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input string what);
        wb(1'b0, a, 32'h0);
        chk(rd, exp, what);
    endtask : rdchk

    // Polls a domain state field with a bounded number of reads.
    task automatic poll(input int d, input logic [1:0] v);
        int n;
        rd = 32'hFFFFFFFF;
        for (n = 0; n < 100 && rd[1:0] !== v; n++)
            wb(1'b0, pdsc_pkg::ADR_PWR_STATE0 + 32'(4 * d), 32'h0);
        chk({30'h0, rd[1:0]}, {30'h0, v}, "state poll");
        if (rd[1:0] !== v)
            report_and_stop();
    endtask : poll

    // Boot: strapped domain ends off, others on, and no compare error shows.
    task automatic t_boot();
        poll(3, pdsc_pkg::ST_OFF);
        rdchk(pdsc_pkg::ADR_PWR_STATE0, {30'h0, pdsc_pkg::ST_ON}, "dom0 on");
        rdchk(pdsc_pkg::ADR_CMP_STAT, 32'h0, "cmp after boot");
        rdchk(pdsc_pkg::ADR_ERR_FLAGS, 32'h0, "err after boot");
        chk({28'h0, clk_en}, 32'h7, "clock enables");
        wb(1'b1, pdsc_pkg::ADR_CMP_STAT, 32'h000F0000);
        wb(1'b1, pdsc_pkg::ADR_ERR_FLAGS, 32'h000000C0);
        wb(1'b1, pdsc_pkg::ADR_IRQ_EN_SET, 32'h000000C0);
        wb(1'b1, pdsc_pkg::ADR_PIN_EN_SET, 32'h000000C0);
        repeat (3) @(posedge clk_i);
        chk({30'h0, irq, pin_n}, 32'h1, "no error effect after init");
        rdchk(32'hFFFF0000, 32'h0, "unmapped read");
        chk(vec, 32'h0, "vector");
    endtask : t_boot

    // Software power-down of domain 0, then an attempt to switch it back on.
    task automatic t_pwrdown();
        wb(1'b1, pdsc_pkg::ADR_PWR_CTRL, 32'h0000000A);
        repeat (4) @(posedge clk_i);
        rdchk(pdsc_pkg::ADR_PWR_STATE0, {30'h0, pdsc_pkg::ST_ON}, "ungated start");
        wb(1'b1, pdsc_pkg::ADR_CLKDIS_SET, 32'h00000001);
        @(posedge clk_i);
        chk({28'h0, clk_en}, 32'h6, "dom0 clock gated");
        wb(1'b1, pdsc_pkg::ADR_PWR_CTRL, 32'h0000000A);
        rdchk(pdsc_pkg::ADR_PWR_STATE0, {30'h0, pdsc_pkg::ST_BUSY}, "in progress");
        poll(0, pdsc_pkg::ST_OFF);
        chk({31'h0, pwr_en[0]}, 32'h0, "dom0 enable");
        rdchk(pdsc_pkg::ADR_CMP_STAT, 32'h0, "cmp after off");
        rdchk(pdsc_pkg::ADR_ERR_FLAGS, 32'h0, "err after off");
        wb(1'b1, pdsc_pkg::ADR_PWR_CTRL, 32'h00000000);
        repeat (10) @(posedge clk_i);
        rdchk(pdsc_pkg::ADR_PWR_STATE0, 32'h0, "stays off");
        chk({31'h0, pwr_en[0]}, 32'h0, "enable stays low");
    endtask : t_pwrdown

    // A real mismatch: the held supply stalls the primary copy while the
    // injected copy finishes, so the difference lasts until the primary has also settled off after the hold ends.
    task automatic t_inject();
        wb(1'b1, pdsc_pkg::ADR_CLKDIS_SET, 32'h00000003);
        wb(1'b1, pdsc_pkg::ADR_CHK_CTRL, 32'h00000001);
        pg_hold <= 4'h2;
        wb(1'b1, pdsc_pkg::ADR_PWR_CTRL, 32'h000000A0);
        repeat (40) @(posedge clk_i);
        wb(1'b0, pdsc_pkg::ADR_CMP_STAT, 32'h0);
        chk({31'h0, rd[17]}, 32'h1, "cmp flag dom1");
        wb(1'b0, pdsc_pkg::ADR_ERR_FLAGS, 32'h0);
        chk({31'h0, rd[7]}, 32'h1, "channel 39");
        chk({30'h0, irq, pin_n}, 32'h2, "irq and pin");
        wb(1'b1, pdsc_pkg::ADR_CMP_STAT, 32'h000F0000);
        wb(1'b0, pdsc_pkg::ADR_CMP_STAT, 32'h0);
        chk({31'h0, rd[17]}, 32'h1, "flag set again");
        pg_hold <= 4'h0;
        poll(1, pdsc_pkg::ST_OFF);
        wb(1'b1, pdsc_pkg::ADR_CHK_CTRL, 32'h00000000);
        repeat (60) @(posedge clk_i);
        wb(1'b1, pdsc_pkg::ADR_CMP_STAT, 32'h000F0000);
        rdchk(pdsc_pkg::ADR_CMP_STAT, 32'h0, "cmp cleared");
        wb(1'b1, pdsc_pkg::ADR_ERR_FLAGS, 32'h000000C0);
        rdchk(pdsc_pkg::ADR_ERR_FLAGS, 32'h0, "err cleared");
        repeat (3) @(posedge clk_i);
        chk({30'h0, irq, pin_n}, 32'h1, "outputs idle");
    endtask : t_inject

    // Warm reset restarts the core at address zero with domains untouched.
    task automatic t_warm();
        int n;
        warm <= 1'b1;
        for (n = 0; n < 10 && cpu_rst !== 1'b1; n++)
            @(posedge clk_i);
        chk({31'h0, cpu_rst}, 32'h1, "core reset");
        chk(vec, 32'h0, "vector in warm reset");
        warm <= 1'b0;
        for (n = 0; n < 10 && cpu_rst !== 1'b0; n++)
            @(posedge clk_i);
        chk({31'h0, cpu_rst}, 32'h0, "core released");
        rdchk(pdsc_pkg::ADR_PWR_STATE0, 32'h0, "dom0 after warm");
    endtask : t_warm

    // Only a system reset brings the domain back.
    task automatic t_sysreset();
        rst_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        poll(0, pdsc_pkg::ST_ON);
        poll(3, pdsc_pkg::ST_OFF);
        rdchk(pdsc_pkg::ADR_CMP_STAT, 32'h0, "cmp after reset");
    endtask : t_sysreset

    // Main sequence: reset for 12 cycles, then the scenarios in turn.
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_boot();
        t_pwrdown();
        t_inject();
        t_warm();
        t_sysreset();
        report_and_stop();
    end
endmodule : power_domain_shutdown_check_tb
